// File: pkg/ldcb_consts.vh
`ifndef LDCB_CONSTS_VH
`define LDCB_CONSTS_VH

// Number of device-number values that own a bank
`define LDCB_NDEV          10

// Device numbers of the banks with extra features
`define LDCB_DEV_FLOPPY    0
`define LDCB_DEV_PARALLEL  3
`define LDCB_DEV_SERIAL1   4
`define LDCB_DEV_SERIAL2   5
`define LDCB_DEV_KBD       7

// Register indices
`define LDCB_IDX_DEVNUM    8'h07
`define LDCB_IDX_ACTIVATE  8'h30
`define LDCB_IDX_BASE0_HI  8'h60
`define LDCB_IDX_BASE0_LO  8'h61
`define LDCB_IDX_BASE1_HI  8'h62
`define LDCB_IDX_BASE1_LO  8'h63
`define LDCB_IDX_IRQ0      8'h70
`define LDCB_IDX_IRQ1      8'h72
`define LDCB_IDX_DMA       8'h74

// Field positions
`define LDCB_ACT_BIT       0

// Reset values
`define LDCB_RST_ZERO      8'h00
`define LDCB_RST_DMA       8'h04
`define LDCB_RST_DEVNUM    8'h00
`define LDCB_RST_INDEX     8'h00

// Permitted base address window, twelve address bits
`define LDCB_BASE_MIN      12'h100
`define LDCB_BASE_MAX8     12'hFF8
`define LDCB_BASE_MAX4     12'hFFC
`define LDCB_SPAN8         12'h007
`define LDCB_SPAN4         12'h003

`endif

// File: hw/ldcb_decode.v
`timescale 1ns/1ps
`include "ldcb_consts.vh"

// Address decode of one logical device
module ldcb_decode #(
    parameter [11:0] BASE_MAX = `LDCB_BASE_MAX8,
    parameter [11:0] SPAN     = `LDCB_SPAN8
) (
    input  wire        mclk_in,
    input  wire        rst_in,
    input  wire [15:0] base_in,
    input  wire        active_in,
    input  wire        io_cyc_in,
    input  wire [11:0] io_addr_in,
    output wire        base_ok_out,
    output reg         hit_out
);

    // Base must sit in the window, on its own boundary
    assign base_ok_out = (base_in[15:12] == 4'h0) &&
                         (base_in[11:0] >= `LDCB_BASE_MIN) &&
                         (base_in[11:0] <= BASE_MAX) &&
                         ((base_in[11:0] & SPAN) == 12'h000);

    // Only A11..A0 take part; upper host bits are don't-care
    wire addr_match;
    assign addr_match = ((io_addr_in & ~SPAN) == base_in[11:0]);

    always @(posedge mclk_in) begin
        if (rst_in) begin
            hit_out <= 1'b0;
        end else begin
            // Out-of-window base: cycles to the device are dropped
            hit_out <= io_cyc_in && active_in && base_ok_out &&
                       addr_match;
        end
    end

endmodule

// File: hw/ldcb_bank.v
`timescale 1ns/1ps
`include "ldcb_consts.vh"

module ldcb_bank (
    input  wire                      mclk_in,
    input  wire                      rst_in,
    input  wire                      cfg_mode_in,
    input  wire                      idx_wr_in,
    input  wire                      data_wr_in,
    input  wire                      data_rd_in,
    input  wire [7:0]                wr_data_in,
    input  wire                      pwr_wr_in,
    input  wire [`LDCB_NDEV-1:0]     pwr_bits_in,
    input  wire                      io_cyc_in,
    input  wire [11:0]               io_addr_in,
    output reg  [7:0]                rd_data_out,
    output reg                       rd_valid_out,
    output wire [7:0]                index_out,
    output wire [7:0]                dev_num_out,
    output wire [`LDCB_NDEV-1:0]     dev_active_out,
    output wire [`LDCB_NDEV-1:0]     pwr_bits_out,
    output wire [`LDCB_NDEV-1:0]     dev_base_ok_out,
    output wire [`LDCB_NDEV-1:0]     dev_hit_out,
    output wire [8*`LDCB_NDEV-1:0]   irq_primary_out,
    output wire [7:0]                irq_secondary_out,
    output wire [7:0]                dma_floppy_out,
    output wire [7:0]                dma_parallel_out,
    output wire [7:0]                dma_serial2_out,
    output wire                      irq_edge_high_out
);

    reg  [7:0] index_reg;
    reg  [7:0] dev_num;

    wire       cfg_wr;
    wire       cfg_rd;
    wire [7:0] bank_rd   [0:`LDCB_NDEV-1];
    wire [7:0] bank_irq1 [0:`LDCB_NDEV-1];
    wire [7:0] bank_dma  [0:`LDCB_NDEV-1];
    reg  [7:0] next_rd_data;

    // Outside the configuration state the ports are closed
    assign cfg_wr = data_wr_in && cfg_mode_in;
    assign cfg_rd = data_rd_in && cfg_mode_in;

    assign index_out   = index_reg;
    assign dev_num_out = dev_num;

    // Routed interrupts are fixed active-high edge, ISA style
    assign irq_edge_high_out = 1'b1;

    // Index port, then data port
    always @(posedge mclk_in) begin
        if (rst_in) begin
            index_reg <= `LDCB_RST_INDEX;
        end else if (idx_wr_in && cfg_mode_in) begin
            index_reg <= wr_data_in;
        end
    end

    // Device-number register; registered so the next access sees it
    always @(posedge mclk_in) begin
        if (rst_in) begin
            dev_num <= `LDCB_RST_DEVNUM;
        end else if (cfg_wr && index_reg == `LDCB_IDX_DEVNUM) begin
            dev_num <= wr_data_in;
        end
    end

    genvar i;
    generate
        for (i = 0; i < `LDCB_NDEV; i = i + 1) begin : g_bank
            localparam HAS_B0 = (i == `LDCB_DEV_FLOPPY)   ||
                                (i == `LDCB_DEV_PARALLEL) ||
                                (i == `LDCB_DEV_SERIAL1)  ||
                                (i == `LDCB_DEV_SERIAL2);
            localparam HAS_B1 = (i == `LDCB_DEV_SERIAL2);
            localparam HAS_IRQ1 = (i == `LDCB_DEV_KBD);
            localparam HAS_DMA = (i == `LDCB_DEV_FLOPPY)   ||
                                 (i == `LDCB_DEV_PARALLEL) ||
                                 (i == `LDCB_DEV_SERIAL2);
            // Parallel port may sit on 4-byte boundaries
            localparam [11:0] LIMIT = (i == `LDCB_DEV_PARALLEL) ?
                                      `LDCB_BASE_MAX4 : `LDCB_BASE_MAX8;
            localparam [11:0] SPAN = (i == `LDCB_DEV_PARALLEL) ?
                                     `LDCB_SPAN4 : `LDCB_SPAN8;

            reg        act;
            reg  [7:0] b0_hi;
            reg  [7:0] b0_lo;
            reg  [7:0] b1_hi;
            reg  [7:0] b1_lo;
            reg  [7:0] irq0;
            reg  [7:0] irq1;
            reg  [7:0] dma;
            reg  [7:0] rd_val;
            wire       sel_wr;

            // Bank chosen by the device number
            assign sel_wr = cfg_wr && (dev_num == i);

            // One bit serves as both activate and power control
            always @(posedge mclk_in) begin
                if (rst_in) begin
                    act <= 1'b0;
                end else if (sel_wr &&
                             index_reg == `LDCB_IDX_ACTIVATE) begin
                    act <= wr_data_in[`LDCB_ACT_BIT];
                end else if (pwr_wr_in) begin
                    act <= pwr_bits_in[i];
                end
            end

            always @(posedge mclk_in) begin
                if (rst_in) begin
                    b0_hi <= `LDCB_RST_ZERO;
                    b0_lo <= `LDCB_RST_ZERO;
                    b1_hi <= `LDCB_RST_ZERO;
                    b1_lo <= `LDCB_RST_ZERO;
                    irq0  <= `LDCB_RST_ZERO;
                    irq1  <= `LDCB_RST_ZERO;
                    dma   <= `LDCB_RST_DMA;
                end else if (sel_wr) begin
                    // Unlisted and unused indices drop the write
                    case (index_reg)
                    `LDCB_IDX_BASE0_HI: begin
                        if (HAS_B0) begin
                            b0_hi <= wr_data_in;
                        end
                    end
                    `LDCB_IDX_BASE0_LO: begin
                        if (HAS_B0) begin
                            b0_lo <= wr_data_in;
                        end
                    end
                    `LDCB_IDX_BASE1_HI: begin
                        if (HAS_B1) begin
                            b1_hi <= wr_data_in;
                        end
                    end
                    `LDCB_IDX_BASE1_LO: begin
                        if (HAS_B1) begin
                            b1_lo <= wr_data_in;
                        end
                    end
                    `LDCB_IDX_IRQ0: begin
                        irq0 <= wr_data_in;
                    end
                    `LDCB_IDX_IRQ1: begin
                        if (HAS_IRQ1) begin
                            irq1 <= wr_data_in;
                        end
                    end
                    `LDCB_IDX_DMA: begin
                        if (HAS_DMA) begin
                            dma <= wr_data_in;
                        end
                    end
                    default: begin
                        b0_hi <= b0_hi;
                    end
                    endcase
                end
            end

            // Read view; reserved bits and unused indices give zero
            always @* begin
                rd_val = 8'h00;
                case (index_reg)
                `LDCB_IDX_ACTIVATE: rd_val = {7'h00, act};
                `LDCB_IDX_BASE0_HI: rd_val = HAS_B0 ? b0_hi : 8'h00;
                `LDCB_IDX_BASE0_LO: rd_val = HAS_B0 ? b0_lo : 8'h00;
                `LDCB_IDX_BASE1_HI: rd_val = HAS_B1 ? b1_hi : 8'h00;
                `LDCB_IDX_BASE1_LO: rd_val = HAS_B1 ? b1_lo : 8'h00;
                `LDCB_IDX_IRQ0:     rd_val = irq0;
                `LDCB_IDX_IRQ1:     rd_val = HAS_IRQ1 ? irq1 : 8'h00;
                `LDCB_IDX_DMA:      rd_val = HAS_DMA ? dma : 8'h00;
                default:            rd_val = 8'h00;
                endcase
            end

            assign bank_rd[i]   = rd_val;
            assign bank_irq1[i] = HAS_IRQ1 ? irq1 : 8'h00;
            assign bank_dma[i]  = HAS_DMA ? dma : 8'h00;
            assign irq_primary_out[8*i +: 8] = irq0;

            // Activate and power-control read back the same bit
            assign dev_active_out[i] = act;
            assign pwr_bits_out[i]   = act;

            if (HAS_B0) begin : g_dec
                ldcb_decode #(
                    .BASE_MAX (LIMIT),
                    .SPAN     (SPAN)
                ) u_dec (
                    .mclk_in     (mclk_in),
                    .rst_in      (rst_in),
                    .base_in     ({b0_hi, b0_lo}),
                    .active_in   (act),
                    .io_cyc_in   (io_cyc_in),
                    .io_addr_in  (io_addr_in),
                    .base_ok_out (dev_base_ok_out[i]),
                    .hit_out     (dev_hit_out[i])
                );
            end else begin : g_nodec
                // No relocatable base, so no decode here
                assign dev_base_ok_out[i] = 1'b0;
                assign dev_hit_out[i]     = 1'b0;
            end
        end
    endgenerate

    assign irq_secondary_out = bank_irq1[`LDCB_DEV_KBD];
    assign dma_floppy_out    = bank_dma[`LDCB_DEV_FLOPPY];
    assign dma_parallel_out  = bank_dma[`LDCB_DEV_PARALLEL];
    assign dma_serial2_out   = bank_dma[`LDCB_DEV_SERIAL2];

    // Data port read mux; banks above the last read as zero
    always @* begin
        next_rd_data = 8'h00;
        if (index_reg == `LDCB_IDX_DEVNUM) begin
            next_rd_data = dev_num;
        end else if (index_reg >= `LDCB_IDX_ACTIVATE &&
                     dev_num < `LDCB_NDEV) begin
            next_rd_data = bank_rd[dev_num[3:0]];
        end
    end

    // Read answer one cycle after the strobe; zero when closed
    always @(posedge mclk_in) begin
        if (rst_in) begin
            rd_data_out  <= 8'h00;
            rd_valid_out <= 1'b0;
        end else begin
            rd_valid_out <= data_rd_in;
            if (cfg_rd) begin
                rd_data_out <= next_rd_data;
            end else begin
                rd_data_out <= 8'h00;
            end
        end
    end

endmodule

// File: test/ldcb_bank_asserts.sv
`timescale 1ns/1ps
`include "ldcb_consts.vh"
module ldcb_bank_asserts (
    input wire                  mclk_in,
    input wire                  rst_in,
    input wire                  cfg_mode_in,
    input wire                  idx_wr_in,
    input wire                  data_wr_in,
    input wire                  data_rd_in,
    input wire [7:0]            wr_data_in,
    input wire                  pwr_wr_in,
    input wire                  io_cyc_in,
    input wire [7:0]            rd_data_out,
    input wire                  rd_valid_out,
    input wire [7:0]            index_out,
    input wire [7:0]            dev_num_out,
    input wire [`LDCB_NDEV-1:0] dev_active_out,
    input wire [`LDCB_NDEV-1:0] pwr_bits_out,
    input wire [`LDCB_NDEV-1:0] dev_base_ok_out,
    input wire [`LDCB_NDEV-1:0] dev_hit_out,
    input wire                  irq_edge_high_out
);
    default clocking dc @(posedge mclk_in);
    endclocking
    default disable iff (rst_in);
    sequence s_sel;
        cfg_mode_in && idx_wr_in && wr_data_in == `LDCB_IDX_DEVNUM
        ##1 !idx_wr_in && !data_wr_in
        ##1 cfg_mode_in && data_wr_in && !idx_wr_in;
    endsequence
    AST_RD_VALID: assert property (data_rd_in |=> rd_valid_out)
        else $error("read strobe without valid");
    AST_RD_CAUSE: assert property (rd_valid_out |-> $past(data_rd_in))
        else $error("valid without read strobe");
    AST_RD_OFF: assert property (!cfg_mode_in && data_rd_in
        |=> rd_data_out == 8'h00) else $error("read outside config state");
    AST_IDX: assert property (cfg_mode_in && idx_wr_in
        |=> index_out == $past(wr_data_in)) else $error("index not taken");
    AST_IDX_HOLD: assert property (!cfg_mode_in |=> $stable(index_out))
        else $error("index moved outside config state");
    AST_RESV: assert property (cfg_mode_in && data_rd_in && index_out inside
        {[8'h31:8'h5F], 8'h71, 8'h73, [8'h75:8'hDF]} |=> rd_data_out == 8'h00)
        else $error("reserved index read nonzero");
    AST_SEL: assert property (s_sel |=> dev_num_out == $past(wr_data_in))
        else $error("device number not taken");
    AST_ACT: assert property (cfg_mode_in && data_wr_in && !pwr_wr_in &&
        index_out == `LDCB_IDX_ACTIVATE && dev_num_out < 8'h0A |=>
        dev_active_out[$past(dev_num_out[3:0])] == $past(wr_data_in[0]))
        else $error("activate bit not taken");
    AST_LINK: assert property (pwr_bits_out == dev_active_out)
        else $error("power and activate bits differ");
    AST_HIT: assert property (|dev_hit_out |-> $past(io_cyc_in) &&
        (dev_hit_out & ~$past(dev_active_out & dev_base_ok_out)) == 10'h000)
        else $error("hit on inactive or bad base");
    AST_EDGE: assert property (irq_edge_high_out)
        else $error("interrupt style not edge high");
endmodule
bind ldcb_bank ldcb_bank_asserts u_chk (.mclk_in(mclk_in), .rst_in(rst_in),
    .cfg_mode_in(cfg_mode_in), .idx_wr_in(idx_wr_in),
    .data_wr_in(data_wr_in), .data_rd_in(data_rd_in),
    .wr_data_in(wr_data_in), .pwr_wr_in(pwr_wr_in), .io_cyc_in(io_cyc_in),
    .rd_data_out(rd_data_out), .rd_valid_out(rd_valid_out),
    .index_out(index_out), .dev_num_out(dev_num_out),
    .dev_active_out(dev_active_out), .pwr_bits_out(pwr_bits_out),
    .dev_base_ok_out(dev_base_ok_out), .dev_hit_out(dev_hit_out),
    .irq_edge_high_out(irq_edge_high_out));

// File: test/ldcb_host.sv
`timescale 1ns/1ps
module ldcb_host (
    input  wire       mclk_in,
    output reg        cfg_mode_out = 1'b1,
    output reg        idx_wr_out = 1'b0,
    output reg        data_wr_out = 1'b0,
    output reg        data_rd_out = 1'b0,
    output reg  [7:0] wr_data_out = 8'h00
);
    // Index, data write or data read; strobe spans one rising edge
    task automatic op(input logic [2:0] kind, input logic [7:0] x);
        @(negedge mclk_in);
        {idx_wr_out, data_wr_out, data_rd_out} = kind;
        wr_data_out = x;
        @(negedge mclk_in);
        {idx_wr_out, data_wr_out, data_rd_out} = 3'b000;
        // Released bus shows the inverse so stale data cannot pass
        wr_data_out = ~x;
    endtask
    task automatic set_cfg(input logic on);
        @(negedge mclk_in);
        cfg_mode_out = on;
    endtask
endmodule

// File: test/ldcb_bank_bench.sv
`timescale 1ns/1ps
`include "ldcb_consts.vh"
module ldcb_bank_bench;
    logic        mclk_in = 1'b0;
    logic        rst_in = 1'b1;
    logic        pwr_wr_in = 1'b0;
    logic [9:0]  pwr_bits_in = 10'h000;
    logic        io_cyc_in = 1'b0;
    logic [11:0] io_addr_in = 12'h000;
    wire         cfg, iw, dw, dr, rv;
    wire  [7:0]  wd, rdat;
    wire  [9:0]  act, pwb, hit, bok;
    wire  [79:0] ipri;
    wire  [7:0]  isec, dflp, dpar, dser;
    int          err_count = 0;
    int          samples_checked = 0;
    logic [31:0] seed = 32'h65AAF84C;
    logic [7:0]  expq[$];
    logic [7:0]  mem[10][7];
    logic [7:0]  regs[7] = '{8'h60, 8'h61, 8'h62, 8'h63, 8'h70, 8'h72,
                             8'h74};
    logic [7:0]  resv[10] = '{8'h31, 8'h3F, 8'h40, 8'h5F, 8'h71, 8'h73,
                              8'h75, 8'hA8, 8'hA9, 8'hDF};
    ldcb_host ldcb_host_inst (.mclk_in(mclk_in), .cfg_mode_out(cfg),
        .idx_wr_out(iw), .data_wr_out(dw), .data_rd_out(dr),
        .wr_data_out(wd));
    ldcb_bank ldcb_bank_inst (.mclk_in(mclk_in), .rst_in(rst_in),
        .cfg_mode_in(cfg), .idx_wr_in(iw), .data_wr_in(dw),
        .data_rd_in(dr), .wr_data_in(wd), .pwr_wr_in(pwr_wr_in),
        .pwr_bits_in(pwr_bits_in), .io_cyc_in(io_cyc_in),
        .io_addr_in(io_addr_in), .rd_data_out(rdat), .rd_valid_out(rv),
        .index_out(), .dev_num_out(), .dev_active_out(act),
        .pwr_bits_out(pwb), .dev_base_ok_out(bok), .dev_hit_out(hit),
        .irq_primary_out(ipri), .irq_secondary_out(isec),
        .dma_floppy_out(dflp), .dma_parallel_out(dpar),
        .dma_serial2_out(dser), .irq_edge_high_out());
    initial begin
        forever #4 mclk_in = ~mclk_in;
    end
    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction
    function automatic logic [7:0] exp_of(int d, logic [7:0] i, logic [7:0] x);
        case (i)
            8'h60, 8'h61: return (d inside {0, 3, 4, 5}) ? x : 8'h00;
            8'h62, 8'h63: return (d == 5) ? x : 8'h00;
            8'h70: return x;
            8'h72: return (d == 7) ? x : 8'h00;
            8'h74: return (d inside {0, 3, 5}) ? x : 8'h00;
            default: return 8'h00;
        endcase
    endfunction
    task automatic check(string nm, logic [9:0] got, logic [9:0] ex);
        samples_checked++;
        if (got !== ex) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
        end
    endtask
    task automatic wreg(logic [7:0] i, logic [7:0] x);
        ldcb_host_inst.op(3'b100, i);
        ldcb_host_inst.op(3'b010, x);
    endtask
    task automatic rreg(logic [7:0] i, logic [7:0] ex);
        ldcb_host_inst.op(3'b100, i);
        expq.push_back(ex);
        ldcb_host_inst.op(3'b001, 8'h00);
    endtask
    task automatic probe(logic [11:0] a, logic ex);
        @(negedge mclk_in);
        io_cyc_in = 1'b1;
        io_addr_in = a;
        @(negedge mclk_in);
        io_cyc_in = 1'b0;
        check("dev_hit", {9'h000, hit[4]}, {9'h000, ex});
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // Results are only settled away from the launching edge
    always @(negedge mclk_in) begin
        if (rv === 1'b1) begin
            if (expq.size() == 0)
                check("spare_read", 10'h001, 10'h000);
            else
                check("rd_data", rdat, expq.pop_front());
        end
    end
    initial begin
        repeat (20) @(negedge mclk_in);
        rst_in = 1'b0;
        for (int d = 0; d < 10; d++) begin
            wreg(8'h07, d[7:0]);
            foreach (regs[k])
                rreg(regs[k], exp_of(d, regs[k],
                     (regs[k] == 8'h74) ? 8'h04 : 8'h00));
        end
        check("active", act, 10'h000);
        $display("reset values done");
        for (int d = 0; d < 10; d++) begin
            wreg(8'h07, d[7:0]);
            foreach (regs[k]) begin
                mem[d][k] = rnd();
                wreg(regs[k], mem[d][k]);
                mem[d][k] = exp_of(d, regs[k], mem[d][k]);
            end
        end
        // Read back after all banks are written, so leaks show
        for (int d = 0; d < 10; d++) begin
            wreg(8'h07, d[7:0]);
            foreach (regs[k])
                rreg(regs[k], mem[d][k]);
        end
        for (int d = 0; d < 10; d++)
            check("irq_primary", ipri[8*d +: 8], mem[d][4]);
        check("irq_secondary", isec, mem[7][5]);
        check("dma_floppy", dflp, mem[0][6]);
        check("dma_parallel", dpar, mem[3][6]);
        check("dma_serial2", dser, mem[5][6]);
        foreach (resv[k]) begin
            wreg(resv[k], rnd());
            rreg(resv[k], 8'h00);
        end
        $display("bank contents done");
        wreg(8'h07, 8'h04);
        wreg(8'h30, 8'hFF);
        rreg(8'h30, 8'h01);
        check("active", act, 10'h010);
        check("pwr_bits", pwb, 10'h010);
        @(negedge mclk_in);
        pwr_wr_in = 1'b1;
        pwr_bits_in = 10'h008;
        @(negedge mclk_in);
        pwr_wr_in = 1'b0;
        pwr_bits_in = {rnd(), rnd()};
        rreg(8'h30, 8'h00);
        check("active", act, 10'h008);
        $display("activate link done");
        wreg(8'h60, 8'h03);
        wreg(8'h61, 8'hF8);
        wreg(8'h30, 8'h01);
        check("base_ok", bok[4], 1'b1);
        probe(12'h3FA, 1'b1);
        probe(12'h3FF, 1'b1);
        probe(12'h400, 1'b0);
        wreg(8'h60, 8'h00);
        check("base_ok", bok[4], 1'b0);
        probe(12'h0FA, 1'b0);
        $display("decode done");
        ldcb_host_inst.set_cfg(1'b0);
        rreg(8'h70, 8'h00);
        wreg(8'h30, 8'h00);
        ldcb_host_inst.set_cfg(1'b1);
        rreg(8'h30, 8'h01);
        for (int i = 0; i < 20 && expq.size() != 0; i++)
            @(negedge mclk_in);
        if (expq.size() != 0)
            err_count++;
        $display("config gate done");
        wrap_up();
    end
    initial begin
        repeat (50000) @(posedge mclk_in);
        err_count++;
        wrap_up();
    end
endmodule
